/* core/audio_volume_boost_control.sv */
`default_nettype none
module audio_volume_boost_control #(
  parameter int SAMPLE_W = 16,
  parameter int ATK_STD = 8,
  parameter int ATK_FAST = 2,
  parameter int ATK_SLOW = 32,
  parameter int REL_STD = 64,
  parameter int REL_FAST = 16,
  parameter int REL_SLOW = 256,
  parameter int SOFT_STEP = 8
) (
  // Clocks and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Serial command link from the host
  input wire logic i_cmd_clock,
  input wire logic i_cmd_data,
  input wire logic i_command_latch_strobe_n,
  input wire logic i_long_latch_option,
  // Audio sample stream in
  input wire logic i_sample_valid,
  input wire logic signed [SAMPLE_W-1:0] i_left,
  input wire logic signed [SAMPLE_W-1:0] i_right,
  input wire logic i_pcm_source_dac,
  // Audio sample stream out
  output logic o_sample_valid,
  output logic signed [SAMPLE_W-1:0] o_left,
  output logic signed [SAMPLE_W-1:0] o_right,
  output logic [audio_ctrl_pkg::PCM_W-1:0] o_serial_pcm_out,
  // DAC control outputs
  output logic o_lpf_center,
  output logic o_zero_detect_flag_pin,
  output logic o_dac_clock_enable,
  output logic o_dac_sync_window,
  output logic o_deemphasis_on,
  output logic o_high_cut_on,
  output logic o_pulse_density_invert,
  output logic o_compressor_on,
  // Boost outputs
  output logic [1:0] o_bass_boost_select,
  output logic [1:0] o_high_boost_select,
  output logic [4:0] o_bass_boost_db,
  output logic [4:0] o_high_boost_db
);
  import audio_ctrl_pkg::*;

  // ==========================================
  // Link domain: shift register on the host clock
  logic [WORD_W-1:0] shift_word; // Holds still while the host clock is idle
  logic [WORD_W-1:0] next_shift_word;

  // Shift MSB first on each rising host clock edge
  always_comb begin
    next_shift_word = {shift_word[WORD_W-2:0], i_cmd_data};
  end

  always_ff @(posedge i_cmd_clock or posedge i_rst) begin
    if (i_rst) begin
      shift_word <= '0;
    end else begin
      shift_word <= next_shift_word;
    end
  end

  // ==========================================
  // Strobe synchroniser and low-time qualifier
  logic strobe_meta; // First stage, read by second stage only
  logic strobe_sync;
  logic long_meta;
  logic long_sync;
  logic [LCNT_W-1:0] low_count;
  logic [LCNT_W-1:0] next_low_count;
  logic latch_done; // One accept per low phase
  logic next_latch_done;
  logic latch_fire;
  logic [LCNT_W-1:0] low_need;

  // Two flops per pin
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      strobe_meta <= 1'b1;
      strobe_sync <= 1'b1;
      long_meta <= 1'b0;
      long_sync <= 1'b0;
    end else begin
      strobe_meta <= i_command_latch_strobe_n;
      strobe_sync <= strobe_meta;
      long_meta <= i_long_latch_option;
      long_sync <= long_meta;
    end
  end

  // Count strobe low time; short glitches never latch
  always_comb begin
    low_need = long_sync ? LCNT_W'(LATCH_LONG_CYC) : LCNT_W'(LATCH_MIN_CYC);
    next_low_count = low_count;
    next_latch_done = latch_done;
    latch_fire = 1'b0;
    if (strobe_sync) begin
      // Strobe high: rearm
      next_low_count = '0;
      next_latch_done = 1'b0;
    end else if (!latch_done) begin
      if (low_count >= low_need - LCNT_W'(1)) begin
        latch_fire = 1'b1;
        next_latch_done = 1'b1;
      end else begin
        next_low_count = low_count + LCNT_W'(1);
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      low_count <= '0;
      latch_done <= 1'b0;
    end else begin
      low_count <= next_low_count;
      latch_done <= next_latch_done;
    end
  end

  // ==========================================
  // Setting pages, updated whole at the latch
  logic [WORD_W-1:0] volume_mute_page;
  logic [WORD_W-1:0] dac_mode_page;
  logic [WORD_W-1:0] boost_setting_page;
  logic [WORD_W-1:0] compressor_polarity_page;
  logic [WORD_W-1:0] next_volume_mute_page;
  logic [WORD_W-1:0] next_dac_mode_page;
  logic [WORD_W-1:0] next_boost_setting_page;
  logic [WORD_W-1:0] next_compressor_polarity_page;
  logic cmd_hit;

  // Word is stable here: host clock idles while strobe is low
  always_comb begin
    cmd_hit = latch_fire && (shift_word[ADDR_HI:ADDR_LO] == CMD_ADDR);
    next_volume_mute_page = volume_mute_page;
    next_dac_mode_page = dac_mode_page;
    next_boost_setting_page = boost_setting_page;
    next_compressor_polarity_page = compressor_polarity_page;
    if (cmd_hit) begin
      unique case (shift_word[PAGE_HI:PAGE_LO])
        PAGE_VOLUME: next_volume_mute_page = shift_word;
        PAGE_DAC: next_dac_mode_page = shift_word;
        PAGE_BOOST: next_boost_setting_page = shift_word;
        PAGE_COMP: next_compressor_polarity_page = shift_word;
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      volume_mute_page <= RESET_VOLUME;
      dac_mode_page <= RESET_DAC;
      boost_setting_page <= RESET_BOOST;
      compressor_polarity_page <= RESET_COMP;
    end else begin
      volume_mute_page <= next_volume_mute_page;
      dac_mode_page <= next_dac_mode_page;
      boost_setting_page <= next_boost_setting_page;
      compressor_polarity_page <= next_compressor_polarity_page;
    end
  end

  // ==========================================
  // Field views
  logic zero_detect_analog_mute_off;
  logic soft_mute_on;
  logic [ATTN_W-1:0] attenuation_value;
  logic dac_run;
  logic zero_flag_polarity;
  logic boost_clear;
  logic [1:0] output_word_length;
  logic [1:0] bass_level_select;
  logic [1:0] high_level_select;
  logic [1:0] boost_attack_rate;
  logic [1:0] boost_release_rate;
  logic upper_threshold_select;
  logic lower_threshold_select;

  always_comb begin
    zero_detect_analog_mute_off = volume_mute_page[POS_ZMUTE_OFF];
    soft_mute_on = volume_mute_page[POS_SOFT_MUTE];
    attenuation_value = volume_mute_page[ATTN_HI:ATTN_LO];
    dac_run = dac_mode_page[POS_DAC_RUN];
    zero_flag_polarity = dac_mode_page[POS_ZPOL];
    boost_clear = dac_mode_page[POS_BCLEAR];
    output_word_length = dac_mode_page[OLEN_HI:OLEN_LO];
    bass_level_select = boost_setting_page[BLVL_HI:BLVL_LO];
    high_level_select = boost_setting_page[HLVL_HI:HLVL_LO];
    boost_attack_rate = boost_setting_page[ATK_HI:ATK_LO];
    boost_release_rate = boost_setting_page[REL_HI:REL_LO];
    upper_threshold_select = boost_setting_page[POS_UTH];
    lower_threshold_select = boost_setting_page[POS_LTH];
  end

  // ==========================================
  // Helper functions
  // Samples per one dB step; undefined code 10 runs at standard
  function automatic logic [8:0] rate_period(input logic [1:0] code, input int std_p, input int fast_p,
                                             input int slow_p);
    if (code == RATE_FAST) begin
      rate_period = 9'(fast_p);
    end else if (code == RATE_SLOW) begin
      rate_period = 9'(slow_p);
    end else begin
      rate_period = 9'(std_p);
    end
  endfunction

  // Magnitude, saturating at full scale
  function automatic logic [15:0] magnitude(input logic signed [SAMPLE_W-1:0] s);
    logic [SAMPLE_W:0] wide;
    wide = s[SAMPLE_W-1] ? (SAMPLE_W+1)'(-$signed({s[SAMPLE_W-1], s})) : {1'b0, s};
    magnitude = wide[SAMPLE_W] ? 16'hFFFF : 16'(wide[SAMPLE_W-1:0]);
  endfunction

  // Fraction bits shifted off, leaving 4 below the sample for the wide serial word
  localparam int FRAC_SHIFT = UNITY_SHIFT - (PCM_W - SAMPLE_W);

  // Scale by gain/1024 into a wide word, clipped; its top bits are the sample
  function automatic logic [PCM_W-1:0] scale(input logic signed [SAMPLE_W-1:0] s,
                                             input logic [ATTN_W-1:0] g);
    logic signed [SAMPLE_W+ATTN_W:0] prod;
    logic signed [SAMPLE_W+ATTN_W-FRAC_SHIFT:0] shifted;
    prod = s * $signed({1'b0, g});
    shifted = (SAMPLE_W+ATTN_W-FRAC_SHIFT+1)'(prod >>> FRAC_SHIFT);
    if (shifted > $signed({1'b0, {(PCM_W-1){1'b1}}})) begin
      scale = {1'b0, {(PCM_W-1){1'b1}}};
    end else if (shifted < $signed({1'b1, {(PCM_W-1){1'b0}}})) begin
      scale = {1'b1, {(PCM_W-1){1'b0}}};
    end else begin
      scale = PCM_W'(shifted);
    end
  endfunction

  // ==========================================
  // Dynamic boost tracker
  boost_state_t boost_state;
  boost_state_t next_boost_state;
  logic [4:0] reduction; // dB taken off both boosts
  logic [4:0] next_reduction;
  logic [8:0] rate_count;
  logic [8:0] next_rate_count;
  logic [4:0] bass_target;
  logic [4:0] high_target;
  logic [4:0] max_target;
  logic [15:0] peak;
  logic [15:0] upper_level;
  logic [15:0] lower_level;
  logic [8:0] period;

  // Targets follow selects; boost clear zeroes bass only
  always_comb begin
    unique case (bass_level_select)
      2'h0: bass_target = 5'd10;
      2'h1: bass_target = 5'd14;
      2'h2: bass_target = 5'd18;
      2'h3: bass_target = 5'd22;
    endcase
    unique case (high_level_select)
      2'h0: high_target = 5'd4;
      2'h1: high_target = 5'd6;
      2'h2: high_target = 5'd8;
      2'h3: high_target = 5'd10;
    endcase
    if (boost_setting_page[BSEL_HI:BSEL_LO] == 2'h0 || boost_clear) begin
      bass_target = 5'd0;
    end
    if (boost_setting_page[HSEL_HI:HSEL_LO] == 2'h0) begin
      high_target = 5'd0;
    end
    max_target = (bass_target > high_target) ? bass_target : high_target;
    upper_level = upper_threshold_select ? UTH_HIGH : UTH_LOW;
    lower_level = lower_threshold_select ? LTH_HIGH : LTH_LOW;
    peak = (magnitude(i_left) > magnitude(i_right)) ? magnitude(i_left) : magnitude(i_right);
  end

  // One step per period of samples in the active direction
  always_comb begin
    next_boost_state = boost_state;
    next_reduction = reduction;
    next_rate_count = rate_count;
    period = (boost_state == BOOST_ATTACK) ?
      rate_period(boost_attack_rate, ATK_STD, ATK_FAST, ATK_SLOW) :
      rate_period(boost_release_rate, REL_STD, REL_FAST, REL_SLOW);
    if (reduction > max_target) begin
      next_reduction = max_target; // Never reduce below zero boost
    end
    if (i_sample_valid && dac_run) begin
      unique case (boost_state)
        BOOST_HOLD: begin
          next_rate_count = '0;
          if (peak > upper_level && reduction < max_target) begin
            next_boost_state = BOOST_ATTACK;
          end else if (peak < lower_level && reduction != 5'd0) begin
            next_boost_state = BOOST_RELEASE;
          end
        end
        BOOST_ATTACK: begin
          if (peak <= upper_level || reduction >= max_target) begin
            next_boost_state = BOOST_HOLD;
          end else if (rate_count >= period - 9'd1) begin
            next_rate_count = '0;
            next_reduction = reduction + 5'd1;
          end else begin
            next_rate_count = rate_count + 9'd1;
          end
        end
        BOOST_RELEASE: begin
          if (peak >= lower_level || reduction == 5'd0) begin
            next_boost_state = BOOST_HOLD;
          end else if (rate_count >= period - 9'd1) begin
            next_rate_count = '0;
            next_reduction = reduction - 5'd1;
          end else begin
            next_rate_count = rate_count + 9'd1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      boost_state <= BOOST_HOLD;
      reduction <= '0;
      rate_count <= '0;
    end else begin
      boost_state <= next_boost_state;
      reduction <= next_reduction;
      rate_count <= next_rate_count;
    end
  end

  // ==========================================
  // Volume, soft mute and zero detect
  logic [ATTN_W-1:0] gain; // Ramps so mute does not click
  logic [ATTN_W-1:0] next_gain;
  logic [ATTN_W-1:0] gain_target;
  logic both_zero;

  // Gain walks toward target once per sample
  always_comb begin
    gain_target = soft_mute_on ? '0 : attenuation_value;
    both_zero = (i_left == '0) && (i_right == '0);
    next_gain = gain;
    if (i_sample_valid && dac_run) begin
      // Difference tests, so no sum wraps near full scale
      if (gain < gain_target) begin
        next_gain = (gain_target - gain > ATTN_W'(SOFT_STEP)) ? gain + ATTN_W'(SOFT_STEP) : gain_target;
      end else begin
        next_gain = (gain - gain_target > ATTN_W'(SOFT_STEP)) ? gain - ATTN_W'(SOFT_STEP) : gain_target;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      gain <= RESET_VOLUME[ATTN_HI:ATTN_LO];
    end else begin
      gain <= next_gain;
    end
  end

  // ==========================================
  // Output registers
  logic next_sample_valid;
  logic signed [SAMPLE_W-1:0] next_left;
  logic signed [SAMPLE_W-1:0] next_right;
  logic [PCM_W-1:0] next_pcm;
  logic [PCM_W-1:0] pcm_mask;
  logic [PCM_W-1:0] left_word; // Scaled left with fraction bits
  logic [PCM_W-1:0] right_word;
  logic next_lpf_center;
  logic next_zero_flag;
  logic [4:0] next_bass_db;
  logic [4:0] next_high_db;

  // Stopped DAC clock passes no samples
  always_comb begin
    next_sample_valid = i_sample_valid && dac_run;
    left_word = scale(i_left, gain);
    right_word = scale(i_right, gain);
    next_left = o_left;
    next_right = o_right;
    next_pcm = o_serial_pcm_out;
    next_lpf_center = o_lpf_center;
    next_zero_flag = o_zero_detect_flag_pin;
    unique case (output_word_length)
      OLEN_18: pcm_mask = MASK_18;
      OLEN_16: pcm_mask = MASK_16;
      default: pcm_mask = MASK_20; // Code 11 is undefined
    endcase
    if (!i_pcm_source_dac) begin
      pcm_mask = MASK_20; // Length only applies to DAC data
    end
    if (next_sample_valid) begin
      next_left = $signed(left_word[PCM_W-1 -: SAMPLE_W]);
      next_right = $signed(right_word[PCM_W-1 -: SAMPLE_W]);
      next_pcm = left_word & pcm_mask;
      next_lpf_center = both_zero && !zero_detect_analog_mute_off;
      next_zero_flag = both_zero ? zero_flag_polarity : !zero_flag_polarity;
    end
    next_bass_db = (bass_target > reduction) ? bass_target - reduction : 5'd0;
    next_high_db = (high_target > reduction) ? high_target - reduction : 5'd0;
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_sample_valid <= 1'b0;
      o_left <= '0;
      o_right <= '0;
      o_serial_pcm_out <= '0;
      o_lpf_center <= 1'b0;
      o_zero_detect_flag_pin <= 1'b1;
      o_dac_clock_enable <= 1'b0;
      o_dac_sync_window <= 1'b0;
      o_deemphasis_on <= 1'b0;
      o_high_cut_on <= 1'b0;
      o_pulse_density_invert <= 1'b0;
      o_compressor_on <= 1'b0;
      o_bass_boost_select <= 2'h0;
      o_high_boost_select <= 2'h0;
      o_bass_boost_db <= 5'd0;
      o_high_boost_db <= 5'd0;
    end else begin
      o_sample_valid <= next_sample_valid;
      o_left <= next_left;
      o_right <= next_right;
      o_serial_pcm_out <= next_pcm;
      o_lpf_center <= next_lpf_center;
      o_zero_detect_flag_pin <= next_zero_flag;
      o_dac_clock_enable <= dac_run;
      o_dac_sync_window <= dac_mode_page[POS_SYNC];
      o_deemphasis_on <= dac_mode_page[POS_DEEMPH];
      o_high_cut_on <= dac_mode_page[POS_HICUT];
      o_pulse_density_invert <= compressor_polarity_page[POS_PULSE_DENSITY_INVERT];
      o_compressor_on <= compressor_polarity_page[POS_COMP];
      o_bass_boost_select <= boost_setting_page[BSEL_HI:BSEL_LO];
      o_high_boost_select <= boost_setting_page[HSEL_HI:HSEL_LO];
      o_bass_boost_db <= next_bass_db;
      o_high_boost_db <= next_high_db;
    end
  end
endmodule
`default_nettype wire

/* include/audio_ctrl_pkg.sv */
`default_nettype none
package audio_ctrl_pkg;
  // ==========================================
  // Command word framing
  localparam int WORD_W = 24;
  localparam logic [7:0] CMD_ADDR = 8'hA5;
  localparam int ADDR_HI = 23;
  localparam int ADDR_LO = 16;
  localparam int PAGE_HI = 15;
  localparam int PAGE_LO = 14;
  localparam logic [1:0] PAGE_VOLUME = 2'h0;
  localparam logic [1:0] PAGE_DAC = 2'h1;
  localparam logic [1:0] PAGE_BOOST = 2'h2;
  localparam logic [1:0] PAGE_COMP = 2'h3;
  // ==========================================
  // Page reset images
  localparam logic [WORD_W-1:0] RESET_VOLUME = 24'hA50400;
  localparam logic [WORD_W-1:0] RESET_DAC = 24'hA540A4;
  localparam logic [WORD_W-1:0] RESET_BOOST = 24'hA58000;
  localparam logic [WORD_W-1:0] RESET_COMP = 24'hA5C000;
  // ==========================================
  // Field positions inside the word
  localparam int POS_ZMUTE_OFF = 12;
  localparam int POS_SOFT_MUTE = 11;
  localparam int ATTN_HI = 10;
  localparam int ATTN_LO = 0;
  localparam int POS_DAC_RUN = 13;
  localparam int POS_ZPOL = 12;
  localparam int POS_SYNC = 11;
  localparam int POS_DEEMPH = 10;
  localparam int POS_HICUT = 9;
  localparam int POS_BCLEAR = 8;
  localparam int OLEN_HI = 5;
  localparam int OLEN_LO = 4;
  localparam int BSEL_HI = 13;
  localparam int BSEL_LO = 12;
  localparam int HSEL_HI = 11;
  localparam int HSEL_LO = 10;
  localparam int BLVL_HI = 9;
  localparam int BLVL_LO = 8;
  localparam int HLVL_HI = 7;
  localparam int HLVL_LO = 6;
  localparam int ATK_HI = 5;
  localparam int ATK_LO = 4;
  localparam int REL_HI = 3;
  localparam int REL_LO = 2;
  localparam int POS_UTH = 1;
  localparam int POS_LTH = 0;
  localparam int POS_COMP = 13;
  localparam int POS_PULSE_DENSITY_INVERT = 0;
  // ==========================================
  // Audio path constants
  localparam int ATTN_W = 11;
  localparam int UNITY_SHIFT = 10;
  localparam int PCM_W = 20;
  localparam logic [1:0] OLEN_20 = 2'h0;
  localparam logic [1:0] OLEN_18 = 2'h1;
  localparam logic [1:0] OLEN_16 = 2'h2;
  localparam logic [PCM_W-1:0] MASK_20 = 20'hFFFFF;
  localparam logic [PCM_W-1:0] MASK_18 = 20'hFFFFC;
  localparam logic [PCM_W-1:0] MASK_16 = 20'hFFFF0;
  // Thresholds as 16 bit magnitudes of full scale
  localparam logic [15:0] UTH_LOW = 16'h66D9;
  localparam logic [15:0] UTH_HIGH = 16'h7367;
  localparam logic [15:0] LTH_LOW = 16'h2027;
  localparam logic [15:0] LTH_HIGH = 16'h4D22;
  // Rate codes
  localparam logic [1:0] RATE_STD = 2'h0;
  localparam logic [1:0] RATE_FAST = 2'h1;
  localparam logic [1:0] RATE_SLOW = 2'h3;
  // ==========================================
  // Latch strobe timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int LATCH_MIN_NS = 750;
  localparam int LATCH_LONG_NS = 6000;
  localparam int LATCH_MIN_CYC = (LATCH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LATCH_LONG_CYC = (LATCH_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LCNT_W = 10;
  // Boost states
  typedef enum logic [1:0] {BOOST_HOLD, BOOST_ATTACK, BOOST_RELEASE} boost_state_t;
endpackage
`default_nettype wire

/* tb/host_cmd_model.sv */
`default_nettype none
// ==========================================
// Host side of the serial command link
module host_cmd_model (
  // System clock for strobe timing
  input wire logic i_clock,
  // Command link
  output logic o_cmd_clock,
  output logic o_cmd_data,
  output logic o_strobe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // One link edge inside reset so the shifter is cleared
  initial begin
    o_cmd_clock = 1'b0;
    o_cmd_data = 1'b0;
    o_strobe_n = 1'b1;
    #23 o_cmd_clock = 1'b1;
    #6 o_cmd_clock = 1'b0;
  end
  // Word MSB first on a 12 ns link clock, which stops between words
  task automatic send(input logic [23:0] word, input int low_cyc, input int gap_cyc);
    for (int i = 23; i >= 0; i--) begin
      o_cmd_data = word[i];
      #6 o_cmd_clock = 1'b1;
      #6 o_cmd_clock = 1'b0;
    end
    // Released data line flips, so a stale bit is never reused
    o_cmd_data = ~word[0];
    @(posedge i_clock);
    o_strobe_n <= 1'b0;
    repeat (low_cyc) @(posedge i_clock);
    o_strobe_n <= 1'b1;
    repeat (gap_cyc) @(posedge i_clock);
  endtask
endmodule
`default_nettype wire

/* tb/audio_ctrl_monitor.sv */
`default_nettype none
// ==========================================
// Port checks of the audio control block
module audio_ctrl_monitor #(
  parameter int SAMPLE_W = 16
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Watched ports
  input wire logic i_sample_valid,
  input wire logic signed [SAMPLE_W-1:0] i_left,
  input wire logic o_sample_valid,
  input wire logic signed [SAMPLE_W-1:0] o_left,
  input wire logic [audio_ctrl_pkg::PCM_W-1:0] o_serial_pcm_out,
  input wire logic o_lpf_center,
  input wire logic o_dac_clock_enable,
  input wire logic [1:0] o_bass_boost_select,
  input wire logic [4:0] o_bass_boost_db,
  input wire logic [4:0] o_high_boost_db
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  a_valid_cause: assert property (o_sample_valid |-> $past(i_sample_valid))
    else $error("output valid without input");
  a_stopped_quiet: assert property ((!o_dac_clock_enable ##1 !o_dac_clock_enable) |-> !o_sample_valid)
    else $error("output while stopped");
  a_lpf_live: assert property (o_sample_valid && $past(i_left) != 0 |-> !o_lpf_center)
    else $error("center level on live data");
  a_silence_kept: assert property (o_sample_valid && $past(i_left) == 0 |-> o_left == 0)
    else $error("zero input gave output");
  a_pcm_align: assert property (o_serial_pcm_out[19:4] == o_left)
    else $error("serial word not aligned");
  a_pcm_tail: assert property (o_sample_valid && $past(i_left) == 0 |-> o_serial_pcm_out == '0)
    else $error("zero input gave serial word");
  a_bass_off: assert property ((o_bass_boost_select == 2'h0) [*3] |-> o_bass_boost_db == 5'h00)
    else $error("bass boost while off");
  a_bass_cap: assert property (o_bass_boost_db <= 5'h16)
    else $error("bass boost above top level");
  a_high_cap: assert property (o_high_boost_db <= 5'h0A)
    else $error("high boost above top level");
endmodule
bind audio_volume_boost_control audio_ctrl_monitor #(.SAMPLE_W(SAMPLE_W)) i_mon (
  .i_clock(i_clock), .i_rst(i_rst), .i_sample_valid(i_sample_valid), .i_left(i_left),
  .o_sample_valid(o_sample_valid), .o_left(o_left), .o_serial_pcm_out(o_serial_pcm_out),
  .o_lpf_center(o_lpf_center), .o_dac_clock_enable(o_dac_clock_enable),
  .o_bass_boost_select(o_bass_boost_select), .o_bass_boost_db(o_bass_boost_db),
  .o_high_boost_db(o_high_boost_db));
`default_nettype wire

/* tb/testbench.sv */
`default_nettype none
// ==========================================
// Self-checking bench
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import audio_ctrl_pkg::*;
  logic i_clock = 1'b0, i_rst = 1'b1, long_opt = 1'b0, i_sample_valid = 1'b0, pcm_dac = 1'b1;
  logic signed [15:0] i_left = 16'h0, i_right = 16'h0, o_l, o_r;
  logic cmd_clock, cmd_data, strobe_n, sv, lpf, flag, dck, sync, deem, hcut, pinv, comp;
  logic [19:0] pcm;
  logic [1:0] bsel, hsel;
  logic [4:0] bdb, hdb;
  int num_errors = 0, compares = 0;
  // Expected boost per code
  logic [4:0] bass_db [4] = '{5'h00, 5'h0E, 5'h12, 5'h16};
  logic [4:0] high_db [4] = '{5'h00, 5'h06, 5'h08, 5'h0A};
  // Serial word of 0x7FF at gain 0x401, rear bits cut per length code
  logic [19:0] pcm_exp [4] = '{20'h0800F, 20'h0800C, 20'h08000, 20'h0800F};
  always #5 i_clock = ~i_clock;
  host_cmd_model i_host (.i_clock(i_clock), .o_cmd_clock(cmd_clock), .o_cmd_data(cmd_data), .o_strobe_n(strobe_n));
  // Fast rates keep the boost loop short
  audio_volume_boost_control #(.ATK_FAST(2), .REL_FAST(2)) i_dut (
    .i_clock(i_clock), .i_rst(i_rst), .i_cmd_clock(cmd_clock), .i_cmd_data(cmd_data),
    .i_command_latch_strobe_n(strobe_n), .i_long_latch_option(long_opt), .i_sample_valid(i_sample_valid),
    .i_left(i_left), .i_right(i_right), .i_pcm_source_dac(pcm_dac), .o_sample_valid(sv), .o_left(o_l),
    .o_right(o_r), .o_serial_pcm_out(pcm), .o_lpf_center(lpf), .o_zero_detect_flag_pin(flag),
    .o_dac_clock_enable(dck), .o_dac_sync_window(sync), .o_deemphasis_on(deem), .o_high_cut_on(hcut),
    .o_pulse_density_invert(pinv), .o_compressor_on(comp), .o_bass_boost_select(bsel),
    .o_high_boost_select(hsel), .o_bass_boost_db(bdb), .o_high_boost_db(hdb));
  // ==========================================
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [1:0] page, input logic [13:0] bits);
    i_host.send({CMD_ADDR, page, bits}, 80, 20);
  endtask
  task automatic smp(input logic [15:0] l);
    @(posedge i_clock);
    i_sample_valid <= 1'b1;
    i_left <= l;
    i_right <= l;
    @(posedge i_clock);
    i_sample_valid <= 1'b0;
    #1 chk(sv, 1'b1);
  endtask
  task automatic end_of_test();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_dac();
    cmd(PAGE_DAC, 14'h3E00);
    chk({dck, sync, deem, hcut}, 4'hF);
    cmd(PAGE_DAC, 14'h3000);
    chk({dck, sync, deem, hcut}, 4'h8);
    i_host.send({8'hA4, PAGE_DAC, 14'h0}, 80, 20);
    chk(dck, 1'b1);
    i_host.send({CMD_ADDR, PAGE_DAC, 14'h0}, 40, 20);
    chk(dck, 1'b1);
    long_opt <= 1'b1;
    i_host.send({CMD_ADDR, PAGE_DAC, 14'h0}, 300, 1100);
    chk(dck, 1'b1);
    i_host.send({CMD_ADDR, PAGE_DAC, 14'h0}, 610, 1100);
    chk(dck, 1'b0);
    long_opt <= 1'b0;
    cmd(PAGE_DAC, 14'h3000);
  endtask
  task automatic t_audio();
    smp(16'h1000);
    chk({o_l, lpf, flag}, {16'h1000, 2'b00});
    chk(o_r, 16'h1000);
    smp(16'h0000);
    chk({lpf, flag}, 2'b11);
    cmd(PAGE_VOLUME, 14'h1400);
    smp(16'h0000);
    chk(lpf, 1'b0);
    cmd(PAGE_VOLUME, 14'h0200);
    repeat (80) smp(16'h1000);
    chk(o_l, 16'h0800);
    cmd(PAGE_VOLUME, 14'h0A00);
    repeat (80) smp(16'h1000);
    chk(o_l, 16'h0000);
    cmd(PAGE_VOLUME, 14'h0400);
    repeat (80) smp(16'h0100);
  endtask
  task automatic t_boost();
    for (logic [2:0] k = 0; k < 4; k++) begin
      cmd(PAGE_BOOST, {k[1:0], (k == 1) ? 2'h2 : k[1:0], k[1:0], k[1:0], 6'h14});
      chk({bsel, bdb, hdb}, {k[1:0], bass_db[k[1:0]], high_db[k[1:0]]});
      chk(hsel, ((k == 1) ? 2'h2 : k[1:0]));
    end
    repeat (20) smp(16'h7FFF);
    chk(bdb < 5'h16, 1'b1);
    repeat (40) smp(16'h0100);
    chk(bdb, 5'h16);
    cmd(PAGE_DAC, 14'h3100);
    chk(bdb, 5'h00);
    cmd(PAGE_DAC, 14'h3000);
    chk(bdb, 5'h16);
  endtask
  task automatic t_comp();
    cmd(PAGE_COMP, 14'h2001);
    chk({comp, pinv}, 2'b11);
    cmd(PAGE_COMP, 14'h0000);
    chk({comp, pinv}, 2'b00);
    cmd(PAGE_VOLUME, 14'h0401);
    smp(16'h07FF);
    chk(pcm, 20'h07FF0);
    for (logic [2:0] k = 0; k < 4; k++) begin
      cmd(PAGE_DAC, {8'hC0, k[1:0], 4'h0});
      smp(16'h07FF);
      chk(pcm, pcm_exp[k[1:0]]);
    end
    cmd(PAGE_DAC, 14'h3020);
    pcm_dac <= 1'b0;
    smp(16'h07FF);
    chk(pcm, 20'h0800F);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (3) @(posedge i_clock);
    #1 chk({flag, dck}, 2'b10);
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    t_dac();
    t_audio();
    t_boost();
    t_comp();
    end_of_test();
  end
  // Watchdog well beyond the expected run
  initial begin
    #500000;
    num_errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
